// *** acs_pkg.sv ***
// Constants for the calibration and reset sequencer of the converter.
// Assumes one 250 MHz system clock; only error lines print a time.
package acs_pkg;
    localparam int DATA_W = 24;
    localparam int ADDR_W = 4;
    localparam int RATE_W = 16;
    // Operating mode codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_CONT = 3'h1;
    localparam logic [2:0] MODE_SINGLE = 3'h2;
    localparam logic [2:0] MODE_STBY = 3'h3;
    localparam logic [2:0] MODE_INT_ZERO = 3'h4;
    localparam logic [2:0] MODE_INT_FULL = 3'h5;
    localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
    localparam logic [2:0] MODE_SYS_FULL = 3'h7;
    // Calibration lengths in output-word periods
    localparam logic [5:0] CAL_SHORT_CHOP = 6'h16;
    localparam logic [5:0] CAL_SHORT_NOCHOP = 6'h18;
    localparam logic [5:0] CAL_LONG_CHOP = 6'h2C;
    localparam logic [5:0] CAL_LONG_NOCHOP = 6'h30;
    // Register addresses
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h1;
    localparam logic [3:0] ADDR_MODE = 4'h2;
    localparam logic [3:0] ADDR_RATE = 4'h3;
    localparam logic [1:0] PAGE_OFFS = 2'h1;
    localparam logic [1:0] PAGE_GAIN = 2'h2;
    // Mode register fields
    localparam int MODE_LSB = 0;
    localparam int CHAN_LSB = 4;
    localparam int AC_BIT = 6;
    localparam int CHOP_BIT = 7;
    localparam int QUICK_BIT = 8;
    localparam int BYPASS_BIT = 9;
    // Status register fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_CAL_BIT = 4;
    localparam int ST_PD_BIT = 5;
    localparam int ST_SETTLED_BIT = 6;
    localparam int ST_READY_BIT = 7;
    // Reset values
    localparam logic [23:0] OFFS_RST = 24'h800000;
    localparam logic [23:0] GAIN_RST = 24'h593CEA;
    localparam logic [15:0] RATE_RST = 16'h0800;
    localparam logic CHOP_RST = 1'b1;
    // Serial reset: 32 ones, counted 0..31
    localparam logic [4:0] ONES_LAST = 5'h1F;
    // Excitation clock: cycles per quarter period, minus one
    localparam logic [7:0] EXC_LAST = 8'h0F;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_CAL = 3'b100
    } acs_state_t;
endpackage

// *** acs_sequencer.sv ***
// Calibration and reset sequencer of a bridge-transducer converter.
// Assumes the filter results, the serial framer and the pins
// surround it; pins are synchronised here, the rest is on clk_sys.
// Operation
// - Calibration drives ready pin and bit high until the routine ends.
// - Mode field is back at idle when ready falls after calibration.
// - Quick-step and stage bypass outputs are held low during calibration.
// - Code 100: internal zero-scale, dc excitation, 22 or 24 periods.
// - Code 101: internal full-scale, dc excitation, 44 or 48 periods.
// - Code 110: system zero-scale on external input, 22 or 24 periods.
// - Code 111: system full-scale on external input, 22 or 24 periods.
// - Zero-scale result goes to selected channel's offset register.
// - Full-scale result goes to selected channel's gain register.
// - System calibrations keep ac excitation when ac select is set.
// - Power-on: defaults, mode 000, filter reset, power-down, flags set.
// - Reset pin: as power-on but analog section stays powered.
// - Standby pin: filter reset, power-down, flags set, state kept.
// - Mode 011 write: standby, filter reset, power-down, flags set.
// - Sync pin: filter reset and flags set, nothing else.
// - Mode 000 write: filter reset and flags set, no power-down.
// - Conversion or calibration write: load mode, restart, set flags.
// - Thirty-two serial ones: defaults, mode 000, serial reset, flags.
// - Data read sets ready back high, all else untouched.
// - Two nonoverlapping excitation clocks, demodulation follows them.
`timescale 1ns/1ns
module acs_sequencer (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [acs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [acs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [acs_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reset_pin_n,
    input wire logic standby_pin_n,
    input wire logic sync_pin_n,
    input wire logic serial_bit_valid,
    input wire logic serial_bit,
    input wire logic [acs_pkg::DATA_W-1:0] conv_word,
    input wire logic [acs_pkg::DATA_W-1:0] cal_result,
    output logic conv_ready_n,
    output logic settled_filter_flag,
    output logic filter_reset,
    output logic serial_if_reset,
    output logic analog_power_down,
    output logic cal_active,
    output logic cal_input_short,
    output logic cal_input_fullscale,
    output logic quick_step_en,
    output logic stage_bypass,
    output logic [1:0] cal_channel,
    output logic bridge_excitation_clock_a,
    output logic bridge_excitation_clock_b,
    output logic demod_invert
);
    import acs_pkg::*;

    typedef struct packed {
        acs_state_t state;
        logic [2:0] mode;
        logic [1:0] chan;
        logic ac_sel;
        logic chop;
        logic quick;
        logic bypass;
        logic [RATE_W-1:0] rate;
        logic [RATE_W-1:0] per_cnt;
        logic [5:0] cal_cnt;
        logic [2:0][DATA_W-1:0] offs;
        logic [2:0][DATA_W-1:0] gain;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] rdata;
        logic ready_n;
        logic settling;
        logic analog_pd;
        logic pd_out;
        logic filter_rst;
        logic serial_rst;
        logic [4:0] ones_cnt;
        logic [1:0] rst_sync;
        logic [1:0] stby_sync;
        logic [1:0] sync_sync;
        logic [7:0] exc_cnt;
        logic [1:0] exc_ph;
        logic exc_a;
        logic exc_b;
        logic demod;
    } acs_regs_t;

    function automatic logic [5:0] cal_periods(input logic [2:0] m,
                                               input logic chop);
        if (m == MODE_INT_FULL) begin
            cal_periods = chop ? CAL_LONG_CHOP : CAL_LONG_NOCHOP;
        end else begin
            cal_periods = chop ? CAL_SHORT_CHOP : CAL_SHORT_NOCHOP;
        end
    endfunction

    // Filter restart with ready and settled flags set
    function automatic acs_regs_t restart(input acs_regs_t r);
        acs_regs_t t;
        t = r;
        t.filter_rst = 1'b1;
        t.ready_n = 1'b1;
        t.settling = 1'b1;
        t.per_cnt = '0;
        t.cal_cnt = '0;
        return t;
    endfunction

    // Register defaults, idle mode, serial interface reset
    function automatic acs_regs_t defaults(input acs_regs_t r);
        acs_regs_t t;
        t = restart(r);
        t.state = ST_IDLE;
        t.mode = MODE_IDLE;
        t.chan = 2'h0;
        t.ac_sel = 1'b0;
        t.chop = CHOP_RST;
        t.quick = 1'b0;
        t.bypass = 1'b0;
        t.rate = RATE_RST;
        t.offs = {3{OFFS_RST}};
        t.gain = {3{GAIN_RST}};
        t.data = '0;
        t.analog_pd = 1'b0;
        t.serial_rst = 1'b1;
        return t;
    endfunction

    function automatic acs_regs_t por_value();
        acs_regs_t t;
        t = defaults('0);
        t.analog_pd = 1'b1;
        t.pd_out = 1'b1;
        t.rst_sync = 2'h3;
        t.stby_sync = 2'h3;
        t.sync_sync = 2'h3;
        return t;
    endfunction

    localparam acs_regs_t S_POR = por_value();

    acs_regs_t s;
    acs_regs_t n;
    logic rst_act;
    logic stby_act;
    logic sync_act;
    logic mode_wr;
    logic data_rd;
    logic ones_evt;
    logic tick;
    logic cal_done;
    logic conv_done;
    logic ac_on;
    logic [2:0] wr_mode;
    logic [1:0] wr_chan;

    assign rst_act = !s.rst_sync[1];
    assign stby_act = !s.stby_sync[1];
    assign sync_act = !s.sync_sync[1];
    assign mode_wr = reg_write && reg_addr == ADDR_MODE;
    assign data_rd = reg_read && reg_addr == ADDR_DATA;
    assign ones_evt = serial_bit_valid && serial_bit
                      && s.ones_cnt == ONES_LAST;
    assign tick = {1'b0, s.per_cnt} + 17'h1 >= {1'b0, s.rate};
    assign cal_done = s.state == ST_CAL && tick
                      && s.cal_cnt == cal_periods(s.mode, s.chop) - 6'h1;
    assign conv_done = s.state == ST_CONV && tick;
    assign wr_mode = reg_wdata[MODE_LSB +: 3];
    assign wr_chan = reg_wdata[CHAN_LSB +: 2];

    always_comb begin
        n = s;
        n.filter_rst = 1'b0;
        n.serial_rst = 1'b0;
        n.rst_sync = {s.rst_sync[0], reset_pin_n};
        n.stby_sync = {s.stby_sync[0], standby_pin_n};
        n.sync_sync = {s.sync_sync[0], sync_pin_n};
        if (serial_bit_valid) begin
            n.ones_cnt = serial_bit ? s.ones_cnt + 5'h1 : 5'h0;
        end
        // Read clears first so a word arriving now still wins
        if (data_rd) begin
            n.ready_n = 1'b1;
        end
        n.per_cnt = (s.state == ST_IDLE || tick) ? '0
                    : s.per_cnt + 16'h1;
        if (conv_done) begin
            n.data = conv_word;
            n.ready_n = 1'b0;
            n.settling = 1'b0;
            if (s.mode == MODE_SINGLE) begin
                n.state = ST_IDLE;
                n.mode = MODE_IDLE;
            end
        end
        if (cal_done) begin
            if (s.mode[0]) begin
                n.gain[s.chan] = cal_result;
            end else begin
                n.offs[s.chan] = cal_result;
            end
            n.mode = MODE_IDLE;
            n.state = ST_IDLE;
            n.ready_n = 1'b0;
            n.settling = 1'b0;
        end else if (s.state == ST_CAL && tick) begin
            n.cal_cnt = s.cal_cnt + 6'h1;
        end
        if (reg_write && reg_addr == ADDR_RATE) begin
            n.rate = reg_wdata[RATE_W-1:0];
        end
        if (reg_write && reg_addr[3:2] == PAGE_OFFS
            && reg_addr[1:0] != 2'h3) begin
            n.offs[reg_addr[1:0]] = reg_wdata;
        end
        if (reg_write && reg_addr[3:2] == PAGE_GAIN
            && reg_addr[1:0] != 2'h3) begin
            n.gain[reg_addr[1:0]] = reg_wdata;
        end
        if (sync_act) begin
            n = restart(n);
        end
        if (mode_wr) begin
            n = restart(n);
            n.mode = wr_mode;
            n.chan = (wr_chan == 2'h3) ? 2'h2 : wr_chan;
            n.ac_sel = reg_wdata[AC_BIT];
            n.chop = reg_wdata[CHOP_BIT];
            n.quick = reg_wdata[QUICK_BIT];
            n.bypass = reg_wdata[BYPASS_BIT];
            n.analog_pd = 1'b0;
            unique case (wr_mode)
                MODE_IDLE: begin
                    n.state = ST_IDLE;
                end
                MODE_STBY: begin
                    n.state = ST_IDLE;
                    n.analog_pd = 1'b1;
                end
                MODE_CONT, MODE_SINGLE: begin
                    n.state = ST_CONV;
                end
                MODE_INT_ZERO, MODE_INT_FULL,
                MODE_SYS_ZERO, MODE_SYS_FULL: begin
                    n.state = ST_CAL;
                end
            endcase
        end
        if (stby_act) begin
            n = restart(n);
        end
        if (ones_evt || rst_act) begin
            n = defaults(n);
        end
        n.pd_out = n.analog_pd | stby_act;
        // Internal calibrations run on dc excitation only
        ac_on = n.ac_sel && !n.pd_out && (n.state == ST_CONV
                || (n.state == ST_CAL && n.mode[1]));
        if (!ac_on) begin
            n.exc_cnt = '0;
            n.exc_ph = 2'h0;
        end else if (s.exc_cnt == EXC_LAST) begin
            n.exc_cnt = '0;
            n.exc_ph = s.exc_ph + 2'h1;
        end else begin
            n.exc_cnt = s.exc_cnt + 8'h1;
        end
        // Quarter phases 1 and 3 are the nonoverlap gaps
        n.exc_a = ac_on && n.exc_ph == 2'h0;
        n.exc_b = ac_on && n.exc_ph == 2'h2;
        n.demod = ac_on && n.exc_ph[1];
        n.rdata = '0;
        if (reg_read) begin
            if (reg_addr == ADDR_STATUS) begin
                n.rdata[ST_MODE_LSB +: 3] = s.mode;
                n.rdata[ST_CAL_BIT] = s.state == ST_CAL;
                n.rdata[ST_PD_BIT] = s.pd_out;
                n.rdata[ST_SETTLED_BIT] = s.settling;
                n.rdata[ST_READY_BIT] = s.ready_n;
            end else if (reg_addr == ADDR_DATA) begin
                n.rdata = s.data;
            end else if (reg_addr == ADDR_MODE) begin
                n.rdata[MODE_LSB +: 3] = s.mode;
                n.rdata[CHAN_LSB +: 2] = s.chan;
                n.rdata[AC_BIT] = s.ac_sel;
                n.rdata[CHOP_BIT] = s.chop;
                n.rdata[QUICK_BIT] = s.quick;
                n.rdata[BYPASS_BIT] = s.bypass;
            end else if (reg_addr == ADDR_RATE) begin
                n.rdata[RATE_W-1:0] = s.rate;
            end else if (reg_addr[1:0] != 2'h3) begin
                if (reg_addr[3:2] == PAGE_OFFS) begin
                    n.rdata = s.offs[reg_addr[1:0]];
                end else if (reg_addr[3:2] == PAGE_GAIN) begin
                    n.rdata = s.gain[reg_addr[1:0]];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s <= S_POR;
        end else if (clk_en) begin
            s <= n;
        end
    end

    assign reg_rdata = s.rdata;
    assign conv_ready_n = s.ready_n;
    assign settled_filter_flag = s.settling;
    assign filter_reset = s.filter_rst | s.pd_out;
    assign serial_if_reset = s.serial_rst;
    assign analog_power_down = s.pd_out;
    assign cal_active = s.state == ST_CAL;
    assign cal_input_short = cal_active && s.mode == MODE_INT_ZERO;
    assign cal_input_fullscale = cal_active && s.mode == MODE_INT_FULL;
    assign quick_step_en = s.quick && !cal_active;
    assign stage_bypass = s.bypass && !cal_active;
    assign cal_channel = s.chan;
    assign bridge_excitation_clock_a = s.exc_a;
    assign bridge_excitation_clock_b = s.exc_b;
    assign demod_invert = s.demod;

    logic quiet;
    assign quiet = clk_en && !mode_wr && !sync_act && !stby_act
                   && !rst_act && !ones_evt;

    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_cal_ready_high: assert property (cal_active |-> conv_ready_n)
        else $error("ready low during calibration");
    a_cal_end_idle: assert property (cal_done && quiet
        |=> !conv_ready_n && s.mode == MODE_IDLE && !cal_active)
        else $error("calibration end left mode or ready wrong");
    a_cal_full_path: assert property (cal_active
        |-> !quick_step_en && !stage_bypass)
        else $error("quick step or bypass active in calibration");
    a_int_cal_dc: assert property (cal_active && !s.mode[1]
        |-> !bridge_excitation_clock_a && !bridge_excitation_clock_b)
        else $error("ac excitation in internal calibration");
    a_cal_len_bound: assert property (cal_active
        |-> s.cal_cnt < cal_periods(s.mode, s.chop))
        else $error("calibration period count overran");
    a_offs_update: assert property (cal_done && quiet && !s.mode[0]
        |=> s.offs[$past(s.chan)] == $past(cal_result))
        else $error("offset register not updated");
    a_gain_update: assert property (cal_done && quiet && s.mode[0]
        |=> s.gain[$past(s.chan)] == $past(cal_result))
        else $error("gain register not updated");
    a_sys_ac_run: assert property (cal_active && s.mode[1] && s.ac_sel
        && !analog_power_down && quiet
        |-> ##[1:80] (bridge_excitation_clock_a || !cal_active
        || analog_power_down))
        else $error("ac excitation stopped in system calibration");
    a_exc_nonoverlap: assert property (!(bridge_excitation_clock_a
        && bridge_excitation_clock_b))
        else $error("excitation clocks overlap");
    a_data_read_set: assert property (data_rd && !conv_done && !cal_done
        && quiet
        |=> conv_ready_n && $stable(s.mode))
        else $error("data read did not set ready");
    a_reset_pin: assert property (rst_act && clk_en
        |=> s.mode == MODE_IDLE && conv_ready_n && settled_filter_flag
        && serial_if_reset && s.offs[0] == OFFS_RST)
        else $error("reset pin effects missing");
    a_serial_ones: assert property (ones_evt && clk_en
        |=> serial_if_reset && s.mode == MODE_IDLE
        && s.gain[1] == GAIN_RST)
        else $error("serial ones reset effects missing");
    a_stby_write: assert property (mode_wr && wr_mode == MODE_STBY
        && clk_en && !rst_act && !ones_evt
        |=> analog_power_down && filter_reset && conv_ready_n)
        else $error("standby write effects missing");
    a_sync_pin: assert property (sync_act && clk_en && !mode_wr
        && !rst_act && !ones_evt
        |=> filter_reset && settled_filter_flag && $stable(s.mode))
        else $error("sync pin effects missing");
endmodule // acs_sequencer

// *** acs_host_model.sv ***
// Host model: clocks a burst of ones, then one zero, into the serial input.
// Assumes the sequencer samples serial_bit on serial_bit_valid, clk_sys.
`timescale 1ns/1ns
module acs_host_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic send,
    input wire logic [5:0] n_ones,
    output logic serial_bit_valid,
    output logic serial_bit,
    output logic busy
);
    logic [6:0] left;
    logic gap;
    assign busy = (left != 7'h00) || serial_bit_valid;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            left <= 7'h00;
            gap <= 1'b0;
            serial_bit_valid <= 1'b0;
            serial_bit <= 1'b0;
        end else if (send) begin
            left <= {1'b0, n_ones} + 7'h01;
        end else if (left != 7'h00 && gap) begin
            left <= left - 7'h01;
            serial_bit_valid <= 1'b1;
            serial_bit <= (left != 7'h01);
            gap <= 1'b0;
        end else begin
            // Data line keeps changing between bits
            serial_bit_valid <= 1'b0;
            serial_bit <= ~serial_bit;
            gap <= 1'b1;
        end
    end
endmodule // acs_host_model

// *** adc_calibration_reset_sequencer_test.sv ***
// Testbench: table of calibrations, then pin, mode and serial events.
// Assumes acs_pkg, acs_sequencer and acs_host_model are compiled first.
`timescale 1ns/1ns
module adc_calibration_reset_sequencer_test;
    import acs_pkg::*;
    typedef struct packed {
        logic [2:0] code;
        logic chop;
        logic ac;
        logic [1:0] chan;
        logic [5:0] n;
        logic [3:0] dest;
        logic [23:0] res;
    } acs_row_t;
    localparam logic [23:0] RATE = 24'h000008;
    acs_row_t rows [8] = '{
        '{3'h5, 1'b1, 1'b0, 2'h0, 6'h2C, 4'h8, 24'h5A0001},
        '{3'h4, 1'b1, 1'b1, 2'h0, 6'h16, 4'h4, 24'h7F0002},
        '{3'h5, 1'b0, 1'b0, 2'h1, 6'h30, 4'h9, 24'h5B0003},
        '{3'h4, 1'b0, 1'b1, 2'h1, 6'h18, 4'h5, 24'h810004},
        '{3'h6, 1'b1, 1'b1, 2'h2, 6'h16, 4'h6, 24'h7E0005},
        '{3'h7, 1'b1, 1'b1, 2'h2, 6'h16, 4'hA, 24'h5C0006},
        '{3'h6, 1'b0, 1'b1, 2'h3, 6'h18, 4'h6, 24'h820007},
        '{3'h7, 1'b0, 1'b0, 2'h1, 6'h18, 4'h9, 24'h5D0008}
    };
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [23:0] reg_wdata = 24'h000000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic reset_pin_n = 1'b1;
    logic standby_pin_n = 1'b1;
    logic sync_pin_n = 1'b1;
    logic [23:0] cal_result = 24'h000000;
    logic send = 1'b0;
    logic [5:0] n_ones = 6'h00;
    logic [23:0] reg_rdata;
    logic [1:0] cal_channel;
    logic serial_bit_valid, serial_bit, busy, conv_ready_n;
    logic settled_filter_flag, filter_reset, serial_if_reset;
    logic analog_power_down, cal_active, cal_input_short;
    logic cal_input_fullscale, quick_step_en, stage_bypass;
    logic exc_a, exc_b, demod_invert;
    logic clk_en = 1'b1;
    logic exc_prev = 1'b0;
    logic overlap = 1'b0;
    logic sir_seen = 1'b0;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int exc_edges = 0;

    acs_sequencer DUT (.clk_sys(clk_sys), .reset_n(reset_n),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .reset_pin_n(reset_pin_n), .standby_pin_n(standby_pin_n),
        .sync_pin_n(sync_pin_n), .serial_bit_valid(serial_bit_valid),
        .serial_bit(serial_bit), .conv_word(24'hA5C3E1),
        .cal_result(cal_result), .conv_ready_n(conv_ready_n),
        .settled_filter_flag(settled_filter_flag),
        .filter_reset(filter_reset), .serial_if_reset(serial_if_reset),
        .analog_power_down(analog_power_down), .cal_active(cal_active),
        .cal_input_short(cal_input_short),
        .cal_input_fullscale(cal_input_fullscale),
        .quick_step_en(quick_step_en), .stage_bypass(stage_bypass),
        .cal_channel(cal_channel), .bridge_excitation_clock_a(exc_a),
        .bridge_excitation_clock_b(exc_b), .demod_invert(demod_invert));
    acs_host_model host (.clk_sys(clk_sys), .reset_n(reset_n),
        .send(send), .n_ones(n_ones), .serial_bit_valid(serial_bit_valid),
        .serial_bit(serial_bit), .busy(busy));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    // Watches outputs away from the launching edge
    always @(negedge clk_sys) begin
        cyc++;
        if (exc_a && !exc_prev) exc_edges++;
        exc_prev = exc_a;
        if (exc_a && exc_b) overlap = 1'b1;
        // Demodulator must follow the excitation halves
        if ((exc_a && demod_invert) || (exc_b && !demod_invert)) begin
            overlap = 1'b1;
        end
        if (serial_if_reset) sir_seen = 1'b1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run;
        end
    end

    task automatic complete_run;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [23:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rc(input logic [3:0] a, input logic [23:0] exp);
        logic [23:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic hold_pin(input int which);
        sir_seen = 1'b0;
        @(posedge clk_sys);
        reset_pin_n <= (which != 0);
        standby_pin_n <= (which != 1);
        sync_pin_n <= (which != 2);
        repeat (5) @(posedge clk_sys);
        #1;
    endtask

    task automatic free_pins;
        @(posedge clk_sys);
        reset_pin_n <= 1'b1;
        standby_pin_n <= 1'b1;
        sync_pin_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic send_ones(input logic [5:0] n);
        int i;
        sir_seen = 1'b0;
        @(posedge clk_sys);
        n_ones <= n;
        send <= 1'b1;
        @(posedge clk_sys);
        send <= 1'b0;
        for (i = 0; i < 200 && (busy || i < 2); i++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic run_cal(input acs_row_t r);
        int cnt;
        int e;
        logic [23:0] d;
        @(posedge clk_sys);
        cal_result <= r.res;
        // Quick-step and bypass requested; calibration must ignore them
        wr(ADDR_MODE, {14'h0, 2'h3, r.chop, r.ac, r.chan, 1'b0, r.code});
        exc_edges = 0;
        cnt = 0;
        do begin
            @(posedge clk_sys);
            #1;
            cnt++;
            if (cnt == 1) begin
                chk({cal_active, conv_ready_n}, 2'h3);
                chk({quick_step_en, stage_bypass}, 2'h0);
                chk(cal_channel, r.dest[1:0]);
                chk(cal_input_short, r.code == 3'h4);
                chk(cal_input_fullscale, r.code == 3'h5);
            end
        end while (conv_ready_n !== 1'b0 && cnt < 600);
        e = exc_edges;
        chk(24'(cnt), 24'(r.n) * RATE);
        chk(cal_active, 1'b0);
        if (r.code[1] && r.ac) chk(24'(e > 0), 24'h1);
        if (!r.code[1]) chk(24'(e), 24'h0);
        rc(ADDR_STATUS, 24'h000000);
        rc(r.dest, r.res);
        rd(ADDR_DATA, d);
        chk({conv_ready_n, settled_filter_flag}, 2'h2);
        rc(ADDR_STATUS, 24'h000080);
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        chk({conv_ready_n, settled_filter_flag, analog_power_down}, 3'h7);
        rc(ADDR_STATUS, 24'h0000E0);
        rc(ADDR_MODE, {16'h0, CHOP_RST, 7'h00});
        rc(4'h6, OFFS_RST);
        rc(4'hA, GAIN_RST);
        rc(ADDR_RATE, {8'h00, RATE_RST});
        wr(4'hF, 24'hFFFFFF);
        rc(4'hF, 24'h000000);
        wr(ADDR_RATE, RATE);
        for (int k = 0; k < 8; k++) run_cal(rows[k]);
        chk(overlap, 1'b0);
        // Single conversion falls back to idle after one word
        wr(ADDR_MODE, 24'h000082);
        repeat (12) @(posedge clk_sys);
        rc(ADDR_STATUS, 24'h000000);
        rc(ADDR_MODE, 24'h000080);
        wr(ADDR_MODE, 24'h000081);
        #1;
        chk({conv_ready_n, settled_filter_flag, filter_reset}, 3'h7);
        for (int k = 0; k < 40 && conv_ready_n !== 1'b0; k++) begin
            @(posedge clk_sys);
            #1;
        end
        chk(conv_ready_n, 1'b0);
        rc(ADDR_DATA, 24'hA5C3E1);
        hold_pin(2);
        chk({conv_ready_n, settled_filter_flag, filter_reset,
             analog_power_down, sir_seen}, 5'h1C);
        free_pins;
        rc(ADDR_MODE, 24'h000081);
        hold_pin(1);
        chk({conv_ready_n, settled_filter_flag, filter_reset,
             analog_power_down, sir_seen}, 5'h1E);
        rc(ADDR_MODE, 24'h000081);
        free_pins;
        wr(ADDR_MODE, 24'h000083);
        #1;
        chk({conv_ready_n, settled_filter_flag, filter_reset,
             analog_power_down}, 4'hF);
        rc(ADDR_STATUS, 24'h0000E3);
        rc(4'h9, rows[7].res);
        wr(ADDR_MODE, 24'h000080);
        #1;
        chk({conv_ready_n, settled_filter_flag, filter_reset,
             analog_power_down}, 4'hE);
        rc(ADDR_STATUS, 24'h0000C0);
        send_ones(6'h1F);
        chk(sir_seen, 1'b0);
        rc(4'h9, rows[7].res);
        send_ones(6'h20);
        chk(sir_seen, 1'b1);
        rc(4'h9, GAIN_RST);
        rc(ADDR_STATUS, 24'h0000C0);
        // Frozen clock enable must drop a standby write
        clk_en <= 1'b0;
        wr(ADDR_MODE, 24'h000083);
        clk_en <= 1'b1;
        rc(ADDR_MODE, 24'h000080);
        wr(4'h4, 24'h123456);
        wr(ADDR_MODE, 24'h000081);
        hold_pin(0);
        chk({conv_ready_n, settled_filter_flag, filter_reset,
             analog_power_down, sir_seen}, 5'h1D);
        free_pins;
        rc(4'h4, OFFS_RST);
        rc(ADDR_MODE, {16'h0, CHOP_RST, 7'h00});
        complete_run;
    end
endmodule // adc_calibration_reset_sequencer_test
